// >>> verilog/octal_switch_pkg.sv
// shared constants and types for the octal switch serial control logic
package octal_switch_pkg;

  // channel count and word layout, bit 7 = output eight, bit 0 = output one
  localparam int NUM_OUT = 8;
  localparam int MSB_BIT = 7;
  localparam int OUT5_BIT = 4;
  localparam int OUT6_BIT = 5;

  // values after reset
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DRIVE_RESET = 8'h00;

  // system clock rate
  localparam longint MCLK_HZ = 64'd20_000_000;

  // fault filter blanking after a latch, least time in microseconds
  localparam longint FILTER_MIN_US = 64'd100;
  // least time rounds up to whole cycles
  localparam longint FILTER_CYCLES_L = (FILTER_MIN_US * MCLK_HZ + 64'd999_999) / 64'd1_000_000;
  localparam int FILTER_CNT_W = 12;
  localparam logic [FILTER_CNT_W-1:0] FILTER_LAST = FILTER_CNT_W'(FILTER_CYCLES_L - 64'd1);
  localparam logic [FILTER_CNT_W-1:0] FILTER_CNT_RESET = 12'h000;

  // synchroniser layout of the slow pins:
  // {vdd_low, enable, direct six, direct five, overload[7:0], open_load[7:0]}
  localparam int PIN_W = 20;
  localparam int PIN_OPEN_LSB = 0;
  localparam int PIN_OVER_LSB = 8;
  localparam int PIN_IN5 = 16;
  localparam int PIN_IN6 = 17;
  localparam int PIN_EN = 18;
  localparam int PIN_UV = 19;
  localparam logic [PIN_W-1:0] PIN_RESET = 20'h00000;

  // fault filter states
  typedef enum logic [0:0] {
    FILT_BLANK,
    FILT_ARMED
  } filt_state_t;

endpackage : octal_switch_pkg

// >>> verilog/fault_monitor.sv
// shared fault filter timer and per-output sticky fault status
`timescale 1ns/1ps

module fault_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic wipe,
  input wire logic restart,
  input wire logic sense_en,
  input wire logic [7:0] cmd_on,
  // sensed conditions, already synchronised
  input wire logic [7:0] open_load,
  input wire logic [7:0] overload,
  // read side
  input wire logic read_clear,
  input wire logic [7:0] clear_mask,
  output logic [7:0] status
);

  octal_switch_pkg::filt_state_t state_r;
  octal_switch_pkg::filt_state_t state_nxt;
  logic [octal_switch_pkg::FILTER_CNT_W-1:0] cnt_r;
  logic [octal_switch_pkg::FILTER_CNT_W-1:0] cnt_nxt;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic detect_on;

  // filter timer: blank after every latch, then arm detection
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (restart) begin
      state_nxt = octal_switch_pkg::FILT_BLANK;
      cnt_nxt = octal_switch_pkg::FILTER_CNT_RESET;
    end else begin
      case (state_r)
        octal_switch_pkg::FILT_BLANK: begin
          if (cnt_r == octal_switch_pkg::FILTER_LAST) begin
            state_nxt = octal_switch_pkg::FILT_ARMED;
          end else begin
            cnt_nxt = cnt_r + 12'h001;
          end
        end
        octal_switch_pkg::FILT_ARMED: begin
          state_nxt = octal_switch_pkg::FILT_ARMED;
        end
        default: begin
          state_nxt = octal_switch_pkg::FILT_BLANK;
          cnt_nxt = octal_switch_pkg::FILTER_CNT_RESET;
        end
      endcase
    end
  end

  assign detect_on = sense_en && (state_r == octal_switch_pkg::FILT_ARMED);
  assign set_vec = detect_on ? ((~cmd_on & open_load) | (cmd_on & overload)) : 8'h00;
  assign clr_vec = read_clear ? clear_mask : 8'h00;
  // sticky until read, set wins over clear
  assign status_nxt = (status_r & ~clr_vec) | set_vec;

  always_ff @(posedge mclk) begin
    if (rst || wipe) begin
      state_r <= octal_switch_pkg::FILT_BLANK;
      cnt_r <= octal_switch_pkg::FILTER_CNT_RESET;
      status_r <= octal_switch_pkg::STATUS_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      status_r <= status_nxt;
    end
  end

  assign status = status_r;

endmodule : fault_monitor

// >>> verilog/octal_switch_serial_control.sv
// serial control, output latch, direct drive and fault reporting of the octal switch
`timescale 1ns/1ps

module octal_switch_serial_control (
  // system clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial link, runs on its own clock
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  // direct drive inputs for pwm
  input wire logic direct_drive_input_five,
  input wire logic direct_drive_input_six,
  // global control
  input wire logic enable,
  input wire logic vdd_low,
  // fault sense from the power stage, bit 7 = output eight
  input wire logic [7:0] open_load_sense,
  input wire logic [7:0] overload_sense,
  // gate drive to the power stage, bit 7 = output eight
  output logic [7:0] gate_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // link side, serial clock domain
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic fall_first_r;
  logic rise_first_r;
  logic dout_r;
  logic dout_nxt;

  // system side
  logic cs_meta_r;
  logic cs_sync_r;
  logic cs_prev_r;
  logic cs_rise;
  logic cs_fall;
  logic [octal_switch_pkg::PIN_W-1:0] pin_meta_r;
  logic [octal_switch_pkg::PIN_W-1:0] pin_sync_r;
  logic [7:0] open_s;
  logic [7:0] over_s;
  logic in5_s;
  logic in6_s;
  logic en_s;
  logic uv_s;
  logic [7:0] cmd_r;
  logic [7:0] direct_vec;
  logic [7:0] cmd_on;
  logic [7:0] drive_r;
  logic [7:0] drive_nxt;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  logic [7:0] status;
  logic oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // serial clock domain: shift chain

  // first fall after selection takes the captured fault word;
  // chip select high acts as the reset of this flag
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fall_first_r <= 1'b1;
    end else begin
      fall_first_r <= 1'b0;
    end
  end

  // fault word loaded into chain
  // bit 7 already left on the first rising edge, so only bits 6..0 enter
  // chain shifts msb out
  assign shift_nxt = fall_first_r ? {hold_r[6:0], serial_data_in}
                                  : {shift_r[6:0], serial_data_in};

  // no reset here on purpose: the word must survive chip select rising so
  // the system side can latch it; the system side only reads it after a frame
  always_ff @(negedge sclk) begin
    if (!cs_n) begin
      shift_r <= shift_nxt;
    end
  end

  assign dout_nxt = rise_first_r ? hold_r[octal_switch_pkg::MSB_BIT]
                                 : shift_r[octal_switch_pkg::MSB_BIT];

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rise_first_r <= 1'b1;
      dout_r <= 1'b0;
    end else begin
      rise_first_r <= 1'b0;
      dout_r <= dout_nxt;
    end
  end

  assign serial_data_out = dout_r;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: synchronisers

  // chip select: two flops, then an edge detector on the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
    end else begin
      cs_meta_r <= cs_n;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
    end
  end

  assign cs_rise = cs_sync_r && !cs_prev_r;
  assign cs_fall = !cs_sync_r && cs_prev_r;

  // slow pins and sense lines, two flops each
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_meta_r <= octal_switch_pkg::PIN_RESET;
      pin_sync_r <= octal_switch_pkg::PIN_RESET;
    end else begin
      pin_meta_r <= {vdd_low, enable, direct_drive_input_six,
                     direct_drive_input_five, overload_sense, open_load_sense};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign open_s = pin_sync_r[octal_switch_pkg::PIN_OPEN_LSB +: 8];
  assign over_s = pin_sync_r[octal_switch_pkg::PIN_OVER_LSB +: 8];
  assign in5_s = pin_sync_r[octal_switch_pkg::PIN_IN5];
  assign in6_s = pin_sync_r[octal_switch_pkg::PIN_IN6];
  assign en_s = pin_sync_r[octal_switch_pkg::PIN_EN];
  assign uv_s = pin_sync_r[octal_switch_pkg::PIN_UV];

  ////////////////////////////////////////////////////////////////////////////
  // system domain: command latch and drive

  // chain is quiet once chip select is high and the clock parked low, so the
  // word is stable by the time the synchronised rise reaches this latch
  always_ff @(posedge mclk) begin
    if (rst || uv_s) begin
      cmd_r <= octal_switch_pkg::CMD_RESET;
    end else if (cs_rise) begin
      cmd_r <= shift_r;
    end
  end

  assign direct_vec = {2'b00, in6_s, in5_s, 4'h0};
  assign cmd_on = cmd_r | direct_vec;
  assign drive_nxt = en_s ? cmd_on : 8'h00;

  always_ff @(posedge mclk) begin
    if (rst || uv_s) begin
      drive_r <= octal_switch_pkg::DRIVE_RESET;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign gate_drive = drive_r;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: fault status and read capture

  fault_monitor u_fault_monitor (
    .mclk(mclk),
    .rst(rst),
    .wipe(uv_s),
    .restart(cs_rise),
    .sense_en(en_s),
    .cmd_on(cmd_on),
    .open_load(open_s),
    .overload(over_s),
    .read_clear(cs_fall),
    .clear_mask(hold_r),
    .status(status)
  );

  assign hold_nxt = en_s ? status : 8'h00;

  // the hold word follows status gated by enable while deselected and freezes once the
  // synchronised select falls; the link side reads it only while selected
  always_ff @(posedge mclk) begin
    if (rst || uv_s) begin
      hold_r <= octal_switch_pkg::STATUS_RESET;
    end else if (cs_sync_r) begin
      hold_r <= hold_nxt;
    end
  end

  // data output enable; lags the pin by the synchroniser depth plus one cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= !cs_sync_r;
    end
  end

  assign serial_data_out_oe = oe_r;

endmodule : octal_switch_serial_control

// >>> verif/octal_switch_assertions.sv
// checker for the pin behaviour of the octal switch control
`timescale 1ns/1ps

module octal_switch_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control pins
  input wire logic cs_n,
  input wire logic enable,
  input wire logic vdd_low,
  input wire logic direct_drive_input_five,
  input wire logic direct_drive_input_six,
  // outputs
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  input wire logic [7:0] gate_drive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // select held long enough to pass the synchronisers
  sequence s_desel;
    cs_n [*5];
  endsequence
  sequence s_sel;
    (!cs_n) [*5];
  endsequence
  property p_oe_off;
    s_desel |-> !serial_data_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
  property p_dout_idle;
    cs_n |-> !serial_data_out;
  endproperty
  a_dout_idle: assert property (p_dout_idle) else $error("data out not idle");
  property p_oe_on;
    s_sel |-> serial_data_out_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("data out not driven while selected");
  property p_uv_off;
    vdd_low [*5] |-> gate_drive == 8'h00;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("drive on at low supply");
  property p_en_off;
    (!enable) [*5] |-> gate_drive == 8'h00;
  endproperty
  a_en_off: assert property (p_en_off) else $error("drive on while disabled");
  property p_direct;
    (enable && !vdd_low && direct_drive_input_five) [*5] |-> gate_drive[4];
  endproperty
  a_direct: assert property (p_direct) else $error("direct input five not driving");
  // slack of eight cycles covers the sync and latch delay; both direct inputs move the drive
  property p_hold;
    $stable({cs_n, enable, vdd_low, direct_drive_input_five, direct_drive_input_six}) [*8]
      |-> $stable(gate_drive);
  endproperty
  a_hold: assert property (p_hold) else $error("drive moved without a cause");
  property p_rst_off;
    disable iff (1'b0) rst ##1 rst |-> gate_drive == 8'h00 && !serial_data_out_oe;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("drive on during reset");
endmodule : octal_switch_checker

bind octal_switch_serial_control octal_switch_checker u_chk (.mclk(mclk), .rst(rst),
  .cs_n(cs_n), .enable(enable), .vdd_low(vdd_low),
  .direct_drive_input_five(direct_drive_input_five),
  .direct_drive_input_six(direct_drive_input_six), .serial_data_out(serial_data_out),
  .serial_data_out_oe(serial_data_out_oe), .gate_drive(gate_drive));

// >>> verif/switch_host.sv
// serial host model driving the link of the switch
`timescale 1ns/1ps

module switch_host (
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    serial_data_in = 1'b0;
    // a clean rise so the link-side flags start set and data out starts cleared
    #1 cs_n = 1'b1;
  end
  // one frame of n bits, rx gathers the returned bits
  task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #7 cs_n = 1'b0;
    #300;
    for (int i = n - 1; i >= 0; i--) begin
      // msb first, data moved mid low phase, never at the fall
      #31.25 serial_data_in = tx[i];
      #31.25 sclk = 1'b1;
      #62.5 rx = {rx[14:0], serial_data_out};
      sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    // released line must not keep its old level
    serial_data_in = ~serial_data_in;
  endtask : frame
endmodule : switch_host

// >>> verif/tb_octal_switch_serial_control.sv
// self-checking bench for the octal switch serial control
`timescale 1ns/1ps

module tb_octal_switch_serial_control;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, din, dout, dout_oe;
  // line seen by the host: a released driver shows the inverse of its last level
  logic miso;
  assign miso = dout_oe ? dout : ~dout;
  logic in5 = 1'b0, in6 = 1'b0, en = 1'b1, uv = 1'b0;
  logic [7:0] open_s = 8'h00, over_s = 8'h00, gate;
  logic [15:0] rx;
  int n_errors = 0, total_checks = 0;
  always #25 mclk = ~mclk;
  octal_switch_serial_control u_dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .serial_data_in(din), .serial_data_out(dout), .serial_data_out_oe(dout_oe),
    .direct_drive_input_five(in5), .direct_drive_input_six(in6), .enable(en),
    .vdd_low(uv), .open_load_sense(open_s), .overload_sense(over_s), .gate_drive(gate));
  switch_host u_host (.sclk(sclk), .cs_n(cs_n), .serial_data_in(din), .serial_data_out(miso));
  ////////////////////////////////////////////////////////////
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // a frame, then room for the latch and the select gap
  task wr(input logic [15:0] w, input int n);
    u_host.frame(w, n, rx);
    cyc(7);
  endtask : wr
  ////////////////////////////////////////////////////////////
  task t_basic;
    check("gate after reset", gate, 8'h00);
    check("oe idle", {7'h00, dout_oe}, 8'h00);
    check("dout idle", {7'h00, dout}, 8'h00);
    wr(16'h00a5, 8);
    check("fault word", rx[7:0], 8'h00);
    check("latched word", gate, 8'ha5);
    wr(16'h3c5a, 16);
    check("chain echo", rx[7:0], 8'h3c);
    check("chain latch", gate, 8'h5a);
    wr(16'h000f, 4);
    check("partial latch", gate, 8'h0f);
    $display("basic test done");
  endtask : t_basic
  // writes spaced beyond the filter time for valid status, one write inside it to see blanking
  task t_fault;
    wr(16'h0000, 8);
    cyc(2100);
    open_s <= 8'h01;
    over_s <= 8'h80;
    cyc(20);
    open_s <= 8'h00;
    cyc(20);
    wr(16'h0080, 8);
    check("open load sticky", rx[7:0], 8'h01);
    cyc(100);
    wr(16'h0080, 8);
    check("blanked fault", rx[7:0], 8'h00);
    cyc(2100);
    wr(16'h0080, 8);
    check("short on output eight", rx[7:0], 8'h80);
    over_s <= 8'h00;
    $display("fault test done");
  endtask : t_fault
  task t_pins;
    en <= 1'b0;
    cyc(6);
    check("enable low", gate, 8'h00);
    en <= 1'b1;
    cyc(6);
    check("enable back", gate, 8'h80);
    // serial command off while direct drive used
    wr(16'h0000, 8);
    in5 <= 1'b1;
    cyc(6);
    check("direct five", gate, 8'h10);
    in5 <= 1'b0;
    in6 <= 1'b1;
    cyc(6);
    check("direct six", gate, 8'h20);
    in6 <= 1'b0;
    wr(16'h00ff, 8);
    uv <= 1'b1;
    cyc(6);
    check("supply low", gate, 8'h00);
    uv <= 1'b0;
    cyc(6);
    check("latch cleared", gate, 8'h00);
    $display("pin test done");
  endtask : t_pins
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(4);
    t_basic;
    t_fault;
    t_pins;
    end_sim;
  end
  // hang guard
  initial begin
    #2ms;
    n_errors++;
    end_sim;
  end
endmodule : tb_octal_switch_serial_control
